/* serial_register_access_frontend.v */
// Two-wire / SPI slave front-end with strap address decoder
//
// What this block does
// - Eleven registers 00h-0Ah; 07h and 08h ignore writes
// - Byte mode keeps the pointer unchanged
// - Sequential mode advances pointer per byte
// - Pointer wraps to 00h after last register
// - Sequential mode is the reset default
// - Byte mode reads repeat the same register
// - Write: control, address, data, each acknowledged
// - Commit only complete bytes; discard interrupted
// - Read: address write, restart, read control
// - SPI samples rising, drives falling, both idles
// - SPI write: select, opcode, address, data
// - SPI read: select, opcode, address, data out
// - Seven comparators decode to 3-bit address
// - Decoder enables, latches, shuts on first clock
// - Latched address held until reset
// - Reset returns registers and state machine
// - Two-wire address: four fixed plus strap bits
// - SPI opcode: seven fixed bits plus R/W
`timescale 1ns/1ps
`default_nettype none
`include "serial_frontend_consts.vh"

module serial_register_access_frontend (
    input wire clk_sys_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire spi_sel_i,
    input wire scl_i,
    input wire sda_i,
    input wire cs_b_i,
    input wire sck_i,
    input wire si_i,
    input wire [6:0] strap_cmp_i,
    output reg sda_o,
    output reg sda_oe_o,
    output reg so_o,
    output reg so_oe_o,
    output reg [2:0] hw_addr_o,
    output reg decoder_active_o,
    output reg reg_wr_o,
    output reg [3:0] reg_wr_addr_o,
    output reg [7:0] reg_wr_data_o
);
    localparam integer EN_INT = `DECODER_ENABLE_CYC;
    localparam integer LATCH_INT = `DECODER_ENABLE_CYC + `ADDRESS_LATCH_CYC;
    localparam [11:0] EN_CYC = EN_INT[11:0];
    localparam [11:0] LATCH_AT = LATCH_INT[11:0];

    reg rst_meta;
    reg rst_sync_b;
    reg [5:0] pin_meta;
    reg [5:0] pin_stab;
    reg [5:0] pin_prev;
    reg [6:0] strap_meta;
    reg [6:0] strap_stab;
    reg [2:0] st;
    reg [3:0] bitcnt;
    reg [7:0] shift;
    reg [7:0] tx;
    reg [3:0] ptr;
    reg rw;
    reg ack_pend;
    reg [11:0] dec_cnt;
    reg latched;
    reg [2:0] strap_code;
    integer k;

    wire [7:0] rd_data;
    wire auto_inc_sel;
    wire sel;
    wire lnk;
    wire lnk_prev;
    wire rise;
    wire fall;
    wire din;
    wire i2c_start;
    wire i2c_stop;
    wire cs_fall;
    wire cs_high;
    wire [7:0] byte_in;
    wire [3:0] next_ptr;
    wire ctrl_match;

    // Reset release through two flops; assertion stays asynchronous
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // Pin synchronisers; only the second stage and later are decoded
    always @(posedge clk_sys_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pin_meta <= `PIN_IDLE;
            pin_stab <= `PIN_IDLE;
            pin_prev <= `PIN_IDLE;
            strap_meta <= 7'h00;
            strap_stab <= 7'h00;
        end else if (ce_i) begin
            pin_meta <= {spi_sel_i, cs_b_i, sck_i, si_i, scl_i, sda_i};
            pin_stab <= pin_meta;
            pin_prev <= pin_stab;
            strap_meta <= strap_cmp_i;
            strap_stab <= strap_meta;
        end
    end

    assign sel = pin_stab[5];
    assign lnk = sel ? pin_stab[3] : pin_stab[1];
    assign lnk_prev = sel ? pin_prev[3] : pin_prev[1];
    assign rise = lnk & ~lnk_prev;
    assign fall = ~lnk & lnk_prev;
    assign din = sel ? pin_stab[2] : pin_stab[0];
    assign i2c_start = !sel && pin_stab[1] && pin_prev[1] &&
                       pin_prev[0] && !pin_stab[0];
    assign i2c_stop = !sel && pin_stab[1] && pin_prev[1] &&
                      !pin_prev[0] && pin_stab[0];
    assign cs_fall = sel && pin_prev[4] && !pin_stab[4];
    assign cs_high = sel && pin_stab[4];
    assign byte_in = {shift[6:0], din};

    // Select bit clear means sequential, so reset lands there
    assign next_ptr = auto_inc_sel ? ptr :
                      (ptr >= `REG_LAST) ? 4'h0 :
                      ptr + 4'h1;
    assign ctrl_match = sel ?
        (byte_in[7:1] == `SPI_FIXED_BITS) :
        (byte_in[7:1] == {`TWO_WIRE_FIXED_BITS, hw_addr_o});

    // Thermometer code: the number of tripped comparators is the code
    always @* begin
        strap_code = 3'h0;
        for (k = 0; k < 7; k = k + 1) begin
            strap_code = strap_code + {2'h0, strap_stab[k]};
        end
    end

    always @(posedge clk_sys_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            dec_cnt <= 12'h000;
            latched <= 1'b0;
            hw_addr_o <= 3'h0;
            decoder_active_o <= 1'b0;
        end else if (ce_i) begin
            if (!latched) begin
                dec_cnt <= dec_cnt + 12'h001;
                if (dec_cnt == EN_CYC) begin
                    decoder_active_o <= 1'b1;
                end
                if (dec_cnt == LATCH_AT) begin
                    hw_addr_o <= strap_code;
                    latched <= 1'b1;
                end
            end else if (rise) begin
                // Early clocks are ignored so the code is always caught
                decoder_active_o <= 1'b0;
            end
        end
    end

    always @(posedge clk_sys_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st <= `ST_IDLE;
            bitcnt <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            ptr <= 4'h0;
            rw <= 1'b0;
            ack_pend <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
            reg_wr_o <= 1'b0;
            reg_wr_addr_o <= 4'h0;
            reg_wr_data_o <= 8'h00;
        end else if (ce_i) begin
            reg_wr_o <= 1'b0;
            if (i2c_stop || cs_high) begin
                // A partial byte is dropped simply by never completing
                st <= `ST_IDLE;
                bitcnt <= 4'h0;
                ack_pend <= 1'b0;
                sda_oe_o <= 1'b0;
                so_oe_o <= 1'b0;
            end else if (i2c_start || cs_fall) begin
                st <= `ST_CTRL;
                bitcnt <= 4'h0;
                ack_pend <= 1'b0;
                sda_oe_o <= 1'b0;
                so_oe_o <= 1'b0;
            end else if (st != `ST_IDLE && rise) begin
                if (bitcnt == `BIT_ACK) begin
                    bitcnt <= 4'h0;
                    // Own acknowledge of the read control byte is no
                    // master acknowledge, so the pointer stays put
                    if (st == `ST_RDATA && !sda_oe_o) begin
                        if (din) begin
                            st <= `ST_IDLE;
                        end else begin
                            ptr <= next_ptr;
                        end
                    end
                end else begin
                    shift <= byte_in;
                    if (sel && bitcnt == `BIT_LAST) begin
                        bitcnt <= 4'h0;
                    end else begin
                        bitcnt <= bitcnt + 4'h1;
                    end
                    if (bitcnt == `BIT_LAST) begin
                        case (st)
                            `ST_CTRL: begin
                                if (ctrl_match) begin
                                    rw <= byte_in[0];
                                    ack_pend <= 1'b1;
                                    if (byte_in[0] && !sel) begin
                                        st <= `ST_RDATA;
                                    end else begin
                                        st <= `ST_REGADR;
                                    end
                                end else begin
                                    st <= `ST_IDLE;
                                end
                            end
                            `ST_REGADR: begin
                                ptr <= byte_in[3:0];
                                ack_pend <= 1'b1;
                                if (sel && rw) begin
                                    st <= `ST_RDATA;
                                end else begin
                                    st <= `ST_WDATA;
                                end
                            end
                            `ST_WDATA: begin
                                reg_wr_o <= 1'b1;
                                reg_wr_addr_o <= ptr;
                                reg_wr_data_o <= byte_in;
                                ptr <= next_ptr;
                                ack_pend <= 1'b1;
                            end
                            `ST_RDATA: begin
                                ack_pend <= 1'b0;
                                if (sel) begin
                                    ptr <= next_ptr;
                                end
                            end
                            default: begin
                                st <= `ST_IDLE;
                            end
                        endcase
                    end
                end
            end else if (st != `ST_IDLE && fall) begin
                if (bitcnt == `BIT_ACK) begin
                    // Drives own acknowledge if one is pending, else releases the line for the master
                    sda_oe_o <= ack_pend;
                    ack_pend <= 1'b0;
                end else if (st == `ST_RDATA) begin
                    if (bitcnt == 4'h0) begin
                        tx <= {rd_data[6:0], 1'b0};
                        so_o <= rd_data[7];
                        sda_oe_o <= !sel && !rd_data[7];
                    end else begin
                        tx <= {tx[6:0], 1'b0};
                        so_o <= tx[7];
                        sda_oe_o <= !sel && !tx[7];
                    end
                    so_oe_o <= sel;
                end else begin
                    sda_oe_o <= 1'b0;
                    so_oe_o <= 1'b0;
                end
            end
        end
    end

    register_bank u_bank (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_sync_b),
        .ce_i(ce_i),
        .wr_en_i(reg_wr_o),
        .wr_addr_i(reg_wr_addr_o),
        .wr_data_i(reg_wr_data_o),
        .rd_addr_i(ptr),
        .rd_data_o(rd_data),
        .auto_increment_select_o(auto_inc_sel)
    );
endmodule // serial_register_access_frontend

`default_nettype wire

/* serial_frontend_consts.vh */
// Constants for the serial register access front-end
`ifndef SERIAL_FRONTEND_CONSTS_VH
`define SERIAL_FRONTEND_CONSTS_VH

// Register addresses
`define REG_DIRECTION_CONTROL 4'h0
`define REG_INPUT_POLARITY 4'h1
`define REG_CHANGE_IRQ_ENABLE 4'h2
`define REG_COMPARE_DEFAULT 4'h3
`define REG_IRQ_COMPARE_SELECT 4'h4
`define REG_DEVICE_CONFIG 4'h5
`define REG_PULLUP_ENABLE 4'h6
`define REG_IRQ_FLAG 4'h7
`define REG_IRQ_CAPTURE 4'h8
`define REG_PORT_PINS 4'h9
`define REG_OUTPUT_LATCH 4'hA
`define REG_LAST 4'hA
`define REG_COUNT 11

// Field positions and reset values
`define CFG_AUTO_INCREMENT_SELECT_BIT 5
`define DIRECTION_CONTROL_RESET 8'hFF
`define REG_RESET 8'h00

// Fixed address bits, values arbitrary
`define TWO_WIRE_FIXED_BITS 4'h4
`define SPI_FIXED_BITS 7'h20

// Interface states
`define ST_IDLE 3'h0
`define ST_CTRL 3'h1
`define ST_REGADR 3'h2
`define ST_WDATA 3'h3
`define ST_RDATA 3'h4

// Pin idle pattern {spi_sel, cs_b, sck, si, scl, sda}
`define PIN_IDLE 6'h13
`define BIT_ACK 4'h8
`define BIT_LAST 4'h7

// Strap decoder timing
`define CLK_SYS_MHZ 50
`define DECODER_ENABLE_DELAY_NS 1000
`define ADDRESS_LATCH_DELAY_NS 1000
`define DECODER_ENABLE_CYC \
    ((`DECODER_ENABLE_DELAY_NS * `CLK_SYS_MHZ + 999) / 1000)
`define ADDRESS_LATCH_CYC \
    ((`ADDRESS_LATCH_DELAY_NS * `CLK_SYS_MHZ + 999) / 1000)

`endif

/* register_bank.v */
// Eleven byte-wide registers with registered read port
`timescale 1ns/1ps
`default_nettype none
`include "serial_frontend_consts.vh"

module register_bank (
    input wire clk_sys_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire wr_en_i,
    input wire [3:0] wr_addr_i,
    input wire [7:0] wr_data_i,
    input wire [3:0] rd_addr_i,
    output reg [7:0] rd_data_o,
    output wire auto_increment_select_o
);
    reg [7:0] mem [0:`REG_COUNT-1];
    integer i;
    wire writable;

    // Flag and capture registers are owned by the port logic
    assign writable = (wr_addr_i <= `REG_LAST) &&
                      (wr_addr_i != `REG_IRQ_FLAG) &&
                      (wr_addr_i != `REG_IRQ_CAPTURE);
    assign auto_increment_select_o =
        mem[`REG_DEVICE_CONFIG][`CFG_AUTO_INCREMENT_SELECT_BIT];

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (i = 0; i < `REG_COUNT; i = i + 1) begin
                mem[i] <= `REG_RESET;
            end
            mem[`REG_DIRECTION_CONTROL] <= `DIRECTION_CONTROL_RESET;
            rd_data_o <= `REG_RESET;
        end else if (ce_i) begin
            if (wr_en_i && writable) begin
                mem[wr_addr_i] <= wr_data_i;
            end
            if (rd_addr_i <= `REG_LAST) begin
                rd_data_o <= mem[rd_addr_i];
            end else begin
                rd_data_o <= `REG_RESET;
            end
        end
    end
endmodule // register_bank

`default_nettype wire

/* serial_frontend_assertions.sv */
// Port checks for the serial register access front-end
`timescale 1ns/1ps
`default_nettype none
module serial_frontend_assertions (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic spi_sel_i,
    input wire logic scl_i,
    input wire logic cs_b_i,
    input wire logic sck_i,
    input wire logic [6:0] strap_cmp_i,
    input wire logic sda_oe_o,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic [2:0] hw_addr_o,
    input wire logic reg_wr_o
);
    logic [7:0] up_cnt;
    // Saturates so the strap checks need no wide counter
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            up_cnt <= 8'h00;
        end else if (up_cnt != 8'hff) begin
            up_cnt <= up_cnt + 8'h01;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_pulse; reg_wr_o ##1 !reg_wr_o; endsequence
    sequence s_quiet; !reg_wr_o && !sda_oe_o && !so_oe_o; endsequence
    property p_wr_pulse; reg_wr_o |-> s_pulse; endproperty
    property p_post_reset; $rose(rst_b_i) |-> s_quiet [*3]; endproperty
    property p_hw_early; up_cnt < 8'h63 |-> hw_addr_o == 3'h0; endproperty
    property p_hw_value;
        up_cnt == 8'h78 |-> hw_addr_o == $countones(strap_cmp_i);
    endproperty
    property p_hw_hold; up_cnt >= 8'h80 |=> $stable(hw_addr_o); endproperty
    property p_so_idle; cs_b_i [*4] |-> !so_oe_o; endproperty
    property p_spi_no_sda; spi_sel_i [*4] |-> !sda_oe_o; endproperty
    property p_so_edge;
        $changed(so_o) && so_oe_o && $past(so_oe_o) |-> !$past(sck_i);
    endproperty
    property p_sda_edge; $rose(sda_oe_o) |-> !$past(scl_i); endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write strobe too long");
    a_post_reset: assert property (p_post_reset)
        else $error("outputs busy after reset");
    a_hw_early: assert property (p_hw_early)
        else $error("strap latched early");
    a_hw_value: assert property (p_hw_value)
        else $error("strap code wrong");
    a_hw_hold: assert property (p_hw_hold)
        else $error("strap code moved");
    a_so_idle: assert property (p_so_idle)
        else $error("data out driven while deselected");
    a_spi_no_sda: assert property (p_spi_no_sda)
        else $error("data line pulled in SPI mode");
    a_so_edge: assert property (p_so_edge)
        else $error("data out changed after rising clock");
    a_sda_edge: assert property (p_sda_edge)
        else $error("data line pulled while clock high");
endmodule // serial_frontend_assertions
`default_nettype wire

/* serial_host_model.sv */
// Host master model for the two-wire and SPI pins
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input wire logic sda_oe_i,
    input wire logic so_i,
    output logic spi_sel_o = 1'b0,
    output logic scl_o = 1'b1,
    output logic sda_o,
    output logic cs_b_o = 1'b1,
    output logic sck_o = 1'b0,
    output logic si_o = 1'b0
);
    logic pull = 1'b0;
    logic idle = 1'b0;
    // Pull-up holds the line high unless a party pulls it low
    assign sda_o = !(pull | sda_oe_i);
    task automatic spi_begin(input logic cpol);
        spi_sel_o = 1'b1;
        idle = cpol;
        sck_o = cpol;
        #80 cs_b_o = 1'b0;
        #80;
    endtask
    task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            si_o = tx[i];
            #80 sck_o = 1'b1;
            rx[i] = so_i;
            #80;
        end
    endtask
    task automatic spi_end;
        sck_o = idle;
        #80 cs_b_o = 1'b1;
        si_o = ~si_o;
        #160;
    endtask
    task automatic i2c_start;
        spi_sel_o = 1'b0;
        pull = 1'b0;
        #80 scl_o = 1'b1;
        #80 pull = 1'b1;
        #80 scl_o = 1'b0;
    endtask
    task automatic i2c_stop;
        pull = 1'b1;
        #80 scl_o = 1'b1;
        #80 pull = 1'b0;
        #160;
    endtask
    task automatic i2c_byte(input logic [7:0] tx, input logic mack,
        input int n, output logic [7:0] rx, output logic ack);
        for (int i = 7; i > 7 - n; i--) begin
            pull = !tx[i];
            #80 scl_o = 1'b1;
            rx[i] = sda_o;
            #80 scl_o = 1'b0;
        end
        if (n == 8) begin
            pull = mack;
            #80 scl_o = 1'b1;
            ack = !sda_o;
            #80 scl_o = 1'b0;
        end
    endtask
endmodule // serial_host_model
`default_nettype wire

/* serial_register_access_frontend_tb_top.sv */
// Testbench top for the serial register access front-end
`timescale 1ns/1ps
`default_nettype none
module serial_register_access_frontend_tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [6:0] strap_cmp_i = 7'h1f;
    wire spi_sel, scl, sda, cs_b, sck, si, sda_oe, so, so_oe, dec_on, wr;
    wire sda_d;
    wire [2:0] hw;
    wire [3:0] wa;
    wire [7:0] wd;
    int n_errors = 0;
    int checked = 0;
    logic [11:0] wq[$];
    logic [7:0] rb[3];
    logic [7:0] rx;
    logic ack;
    always #10 clk_sys_i = ~clk_sys_i;
    serial_register_access_frontend uut (.clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i), .ce_i(1'b1), .spi_sel_i(spi_sel), .scl_i(scl),
        .sda_i(sda), .cs_b_i(cs_b), .sck_i(sck), .si_i(si),
        .strap_cmp_i(strap_cmp_i), .sda_o(sda_d), .sda_oe_o(sda_oe), .so_o(so),
        .so_oe_o(so_oe), .hw_addr_o(hw), .decoder_active_o(dec_on),
        .reg_wr_o(wr), .reg_wr_addr_o(wa), .reg_wr_data_o(wd));
    serial_host_model host (.sda_oe_i(sda_oe), .so_i(so),
        .spi_sel_o(spi_sel), .scl_o(scl), .sda_o(sda), .cs_b_o(cs_b),
        .sck_o(sck), .si_o(si));
    always @(posedge clk_sys_i) if (wr) wq.push_back({wa, wd});
    task automatic stop_test;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkwr(input logic [3:0] a, input logic [7:0] d);
        logic [11:0] got;
        got = (wq.size() > 0) ? wq.pop_front() : 12'hxxx;
        chk8(got[11:8] === a ? got[7:0] : 8'hxx, d);
    endtask
    task automatic spi(input logic cpol, input logic [7:0] op, adr,
        input logic [23:0] tx, input int n);
        host.spi_begin(cpol);
        host.spi_byte(op, rx);
        host.spi_byte(adr, rx);
        for (int i = 0; i < n; i++) host.spi_byte(tx[23-8*i -: 8], rb[i]);
        host.spi_end();
    endtask
    task automatic i2c(input logic [7:0] tx, input logic mack, input int n);
        host.i2c_byte(tx, mack, n, rx, ack);
    endtask
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
    initial begin
        #71 rst_b_i = 1'b1;
        #3000;
        chk8({5'h00, hw}, 8'h05);
        chk8({7'h00, dec_on}, 8'h01);
        chk8({7'h00, sda_d}, 8'h00);
        spi(1'b0, 8'h40, 8'h0a, 24'h11_2200, 2);
        chkwr(4'ha, 8'h11);
        chkwr(4'h0, 8'h22);
        chk8({7'h00, dec_on}, 8'h00);
        strap_cmp_i = 7'h03;
        spi(1'b1, 8'h41, 8'h0a, 24'h00_0000, 2);
        chk8(rb[0], 8'h11);
        chk8(rb[1], 8'h22);
        chk8({5'h00, hw}, 8'h05);
        spi(1'b0, 8'h40, 8'h05, 24'h20_0000, 1);
        spi(1'b0, 8'h40, 8'h09, 24'h33_4400, 2);
        spi(1'b1, 8'h41, 8'h09, 24'h00_0000, 3);
        chkwr(4'h5, 8'h20);
        chkwr(4'h9, 8'h33);
        chkwr(4'h9, 8'h44);
        chk8(rb[2], 8'h44);
        spi(1'b0, 8'h40, 8'h08, 24'h55_0000, 1);
        spi(1'b0, 8'h41, 8'h08, 24'h00_0000, 1);
        chkwr(4'h8, 8'h55);
        chk8(rb[0], 8'h00);
        host.i2c_start();
        i2c(8'h4a, 1'b0, 8);
        chk8({7'h00, ack}, 8'h01);
        i2c(8'h06, 1'b0, 8);
        i2c(8'h5a, 1'b0, 8);
        chk8({7'h00, ack}, 8'h01);
        host.i2c_start();
        i2c(8'h4b, 1'b0, 8);
        i2c(8'hff, 1'b1, 8);
        chk8(rx, 8'h5a);
        i2c(8'hff, 1'b0, 8);
        chk8(rx, 8'h5a);
        host.i2c_stop();
        chkwr(4'h6, 8'h5a);
        host.i2c_start();
        i2c(8'h4c, 1'b0, 8);
        chk8({7'h00, ack}, 8'h00);
        host.i2c_stop();
        spi(1'b0, 8'h42, 8'h09, 24'h66_0000, 1);
        host.i2c_start();
        i2c(8'h4a, 1'b0, 8);
        i2c(8'h06, 1'b0, 8);
        i2c(8'hc3, 1'b0, 4);
        host.i2c_stop();
        chk8(8'(wq.size()), 8'h00);
        rst_b_i = 1'b0;
        #80 rst_b_i = 1'b1;
        #3000;
        chk8({5'h00, hw}, 8'h02);
        spi(1'b0, 8'h41, 8'h0a, 24'h00_0000, 2);
        chk8(rb[0], 8'h00);
        chk8(rb[1], 8'hff);
        host.i2c_start();
        i2c(8'h44, 1'b0, 8);
        i2c(8'h0a, 1'b0, 8);
        host.i2c_start();
        i2c(8'h45, 1'b0, 8);
        i2c(8'hff, 1'b1, 8);
        chk8(rx, 8'h00);
        i2c(8'hff, 1'b0, 8);
        chk8(rx, 8'hff);
        host.i2c_stop();
        stop_test();
    end
endmodule // serial_register_access_frontend_tb_top
bind serial_register_access_frontend serial_frontend_assertions chk (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .spi_sel_i(spi_sel_i),
    .scl_i(scl_i), .cs_b_i(cs_b_i), .sck_i(sck_i), .so_o(so_o),
    .strap_cmp_i(strap_cmp_i), .sda_oe_o(sda_oe_o), .so_oe_o(so_oe_o),
    .hw_addr_o(hw_addr_o), .reg_wr_o(reg_wr_o));
`default_nettype wire
